// *** rtl/esc_pkg.sv ***
package esc_pkg;

  // Configuration indices
  localparam logic [7:0] IDX_PAR_SERIAL = 8'h04;
  localparam logic [7:0] IDX_FDC_IDE = 8'h05;
  localparam logic [7:0] IDX_DRIVE_TYPE = 8'h06;

  // Power-up values
  localparam logic [7:0] RST_PAR_SERIAL = 8'h00;
  localparam logic [7:0] RST_FDC_IDE = 8'h00;
  localparam logic [7:0] RST_DRIVE_TYPE = 8'hff;

  // Writable bits; the rest read as zero
  localparam logic [7:0] MASK_PAR_SERIAL = 8'h7f;
  localparam logic [7:0] MASK_FDC_IDE = 8'h7c;

  // Parallel and serial extended setup fields
  localparam int POS_PAR_MODE = 0;
  localparam int POS_PAR_FLOPPY = 2;
  localparam int POS_UART_ONE_DIV12 = 4;
  localparam int POS_UART_TWO_DIV12 = 5;
  localparam int POS_EPP_TYPE = 6;

  // Floppy and IDE extended setup fields
  localparam int POS_NON_BURST = 2;
  localparam int POS_DENSEL = 3;
  localparam int POS_SWAP = 5;
  localparam int POS_EXT_FOUR = 6;

  localparam logic [1:0] PAR_SPP = 2'h0;
  localparam logic [1:0] PAR_EPP_SPP = 2'h1;
  localparam logic [1:0] PAR_ECP = 2'h2;
  localparam logic [1:0] PAR_ECP_EPP = 2'h3;

  localparam logic [1:0] PFD_OPT_ONE = 2'h1;
  localparam logic [1:0] PFD_OPT_TWO = 2'h2;

  localparam logic [1:0] DENSEL_FORCE_HIGH = 2'h2;
  localparam logic [1:0] DENSEL_FORCE_LOW = 2'h3;

  localparam logic [2:0] ECR_MODE_SPP = 3'h0;
  localparam logic [2:0] ECR_MODE_EPP = 3'h4;

  // UART clock dividers
  localparam logic [3:0] UART_DIV_STD = 4'hd;
  localparam logic [3:0] UART_DIV_MUSIC = 4'hc;

  typedef enum logic [1:0] {
    OP_SPP,
    OP_EPP,
    OP_ECP
  } esc_op_mode_t;

  // Request from the floppy core: selected drive and motor lines
  typedef struct packed {
    logic [1:0] driveIdx;
    logic driveActive;
    logic [3:0] motorOn;
  } esc_fdc_sel_t;

endpackage : esc_pkg

// *** rtl/esc_setup_regs.sv ***
// Summary of operation
// - Parallel-serial setup at index 04h, resets 00h
// - Bits 1:0 select parallel port mode
// - Bit 4: first UART divides 13 or 12
// - Bit 5: second UART divides 13 or 12
// - Bit 6 selects EPP 1.9 or 1.7
// - ECP+EPP mode: ecr mode 100 gives EPP
// - ECP modes: ecr mode 000 gives SPP
// - Divide-by-12 yields music rate within one percent
// - Floppy-IDE setup at index 05h, resets 00h
// - Bits 1:0 and 7 read zero, ignore writes
// - Bit 2 selects burst or non-burst DMA
// - Non-burst with the FIFO on: request and interrupt pulse per byte
// - Bit 5 swaps drive and motor 0,1
// - Bit 6 emits encoded selects for four drives
// - Drive-type register at index 06h, resets FFh
// - Drive-type register holds four drive codes
module esc_setup_regs (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic cfgMode,
  input wire logic idxWr,
  input wire logic dataWr,
  input wire logic dataRd,
  input wire logic [7:0] wrData,
  output logic [7:0] rdData,
  output logic [7:0] configIndexRegister,
  output logic [1:0] parMode,
  output logic parPinFloppyOptOne,
  output logic parPinFloppyOptTwo,
  output logic eppVersion17,
  input wire logic ecrModeWr,
  input wire logic [2:0] ecrMode,
  output esc_pkg::esc_op_mode_t parOpMode,
  output logic uartOneDiv12Select,
  output logic uartTwoDiv12Select,
  output logic [1:0] uartClkTick,
  input wire logic fifoEnabled,
  input wire logic fdcDmaReqIn,
  input wire logic fdcIrqIn,
  input wire logic fdcByteDone,
  output logic floppyDmaRequest,
  output logic floppyInterruptRequest,
  input wire logic denselIn,
  output logic densel,
  input esc_pkg::esc_fdc_sel_t fdcSel,
  output logic [1:0] driveSelect,
  output logic [1:0] motorSelect,
  output logic externalFourDriveDecode,
  output logic [7:0] driveTypes
);
  import esc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  logic [7:0] index_r, index_nxt;
  logic [7:0] parSerial_r, parSerial_nxt;
  logic [7:0] fdcIde_r, fdcIde_nxt;
  logic [7:0] drvType_r, drvType_nxt;
  logic [7:0] rdData_r, rdData_nxt;
  esc_op_mode_t opMode_r, opMode_nxt;
  logic [1:0] pfd_r, pfd_nxt;
  logic ecpBased;

  assign ecpBased = parSerial_r[POS_PAR_MODE + 1];
  always_comb
  begin
    index_nxt = index_r;
    parSerial_nxt = parSerial_r;
    fdcIde_nxt = fdcIde_r;
    drvType_nxt = drvType_r;
    rdData_nxt = rdData_r;
    opMode_nxt = opMode_r;
    if (cfgMode && idxWr)
      index_nxt = wrData;
    // Outside configuration mode the data port does nothing
    if (cfgMode && dataWr)
      case (index_r)
        IDX_PAR_SERIAL: parSerial_nxt = wrData & MASK_PAR_SERIAL;
        IDX_FDC_IDE: fdcIde_nxt = wrData & MASK_FDC_IDE;
        IDX_DRIVE_TYPE: drvType_nxt = wrData;
        default: ;
      endcase
    if (cfgMode && dataRd)
      case (index_r)
        IDX_PAR_SERIAL: rdData_nxt = parSerial_r;
        IDX_FDC_IDE: rdData_nxt = fdcIde_r;
        IDX_DRIVE_TYPE: rdData_nxt = drvType_r;
        default: rdData_nxt = 8'h00;
      endcase
    // Operating mode follows the setup field, then ecr writes in ECP modes
    if (cfgMode && dataWr && index_r == IDX_PAR_SERIAL)
      case (wrData[POS_PAR_MODE +: 2])
        PAR_SPP: opMode_nxt = OP_SPP;
        PAR_EPP_SPP: opMode_nxt = OP_EPP;
        default: opMode_nxt = OP_ECP;
      endcase
    else if (ecrModeWr && ecpBased)
      if (ecrMode == ECR_MODE_SPP)
        opMode_nxt = OP_SPP;
      else if (ecrMode == ECR_MODE_EPP && parSerial_r[POS_PAR_MODE +: 2] == PAR_ECP_EPP)
        opMode_nxt = OP_EPP;
      else
        opMode_nxt = OP_ECP;
    // Decoded ahead of the flop so the pin-floppy outputs leave registered
    pfd_nxt[0] = parSerial_nxt[POS_PAR_FLOPPY +: 2] == PFD_OPT_ONE;
    pfd_nxt[1] = parSerial_nxt[POS_PAR_FLOPPY +: 2] == PFD_OPT_TWO;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      index_r <= 8'h00;
      parSerial_r <= RST_PAR_SERIAL;
      fdcIde_r <= RST_FDC_IDE;
      drvType_r <= RST_DRIVE_TYPE;
      rdData_r <= 8'h00;
      opMode_r <= OP_SPP;
      pfd_r <= 2'h0;
    end
    else
    begin
      index_r <= index_nxt;
      parSerial_r <= parSerial_nxt;
      fdcIde_r <= fdcIde_nxt;
      drvType_r <= drvType_nxt;
      rdData_r <= rdData_nxt;
      opMode_r <= opMode_nxt;
      pfd_r <= pfd_nxt;
    end
  end

  assign rdData = rdData_r;
  assign configIndexRegister = index_r;
  assign parMode = parSerial_r[POS_PAR_MODE +: 2];
  assign parPinFloppyOptOne = pfd_r[0];
  assign parPinFloppyOptTwo = pfd_r[1];
  assign eppVersion17 = parSerial_r[POS_EPP_TYPE];
  assign parOpMode = opMode_r;
  assign uartOneDiv12Select = parSerial_r[POS_UART_ONE_DIV12];
  assign uartTwoDiv12Select = parSerial_r[POS_UART_TWO_DIV12];
  assign externalFourDriveDecode = fdcIde_r[POS_EXT_FOUR];
  assign driveTypes = drvType_r;

  //////////////////////////////////////////////////////////////////////////////
  // UART clock prescalers, one per port
  // Wrap on >= so a divider change mid-period never runs the count out

  logic [1:0] div12Sel;
  assign div12Sel = {parSerial_r[POS_UART_TWO_DIV12], parSerial_r[POS_UART_ONE_DIV12]};

  genvar gu;
  generate
    for (gu = 0; gu < 2; gu++)
    begin : g_uart_div
      logic [3:0] cnt_r, cnt_nxt;
      logic tick_r, tick_nxt;
      logic [3:0] lastCnt;
      always_comb
      begin
        lastCnt = (div12Sel[gu] ? UART_DIV_MUSIC : UART_DIV_STD) - 4'h1;
        tick_nxt = cnt_r >= lastCnt;
        cnt_nxt = tick_nxt ? 4'h0 : cnt_r + 4'h1;
      end
      always_ff @(posedge clock)
      begin
        if (sys_rst)
        begin
          cnt_r <= 4'h0;
          tick_r <= 1'b0;
        end
        else
        begin
          cnt_r <= cnt_nxt;
          tick_r <= tick_nxt;
        end
      end
      assign uartClkTick[gu] = tick_r;
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Floppy DMA request and interrupt shaping

  logic nonBurst;
  logic [1:0] fdcLineIn;
  logic [1:0] fdcLineOut;
  assign nonBurst = fdcIde_r[POS_NON_BURST] && fifoEnabled;
  assign fdcLineIn = {fdcIrqIn, fdcDmaReqIn};

  genvar gl;
  generate
    for (gl = 0; gl < 2; gl++)
    begin : g_fdc_line
      logic armed_r, armed_nxt;
      logic out_r, out_nxt;
      // One strobe per byte; re-armed by the byte completion or the line dropping
      always_comb
      begin
        armed_nxt = armed_r;
        if (!nonBurst)
        begin
          out_nxt = fdcLineIn[gl];
          armed_nxt = 1'b1;
        end
        else
        begin
          out_nxt = fdcLineIn[gl] && armed_r;
          if (out_nxt)
            armed_nxt = 1'b0;
          if (fdcByteDone || !fdcLineIn[gl])
            armed_nxt = 1'b1;
        end
      end
      always_ff @(posedge clock)
      begin
        if (sys_rst)
        begin
          armed_r <= 1'b1;
          out_r <= 1'b0;
        end
        else
        begin
          armed_r <= armed_nxt;
          out_r <= out_nxt;
        end
      end
      assign fdcLineOut[gl] = out_r;
    end
  endgenerate

  assign floppyDmaRequest = fdcLineOut[0];
  assign floppyInterruptRequest = fdcLineOut[1];

  //////////////////////////////////////////////////////////////////////////////
  // Drive select, motor and density outputs

  logic [1:0] drvSel_r, drvSel_nxt;
  logic [1:0] motor_r, motor_nxt;
  logic densel_r, densel_nxt;
  logic [1:0] swIdx;
  logic swap;
  assign swap = fdcIde_r[POS_SWAP];

  always_comb
  begin
    swIdx = fdcSel.driveIdx;
    if (swap && !fdcSel.driveIdx[1])
      swIdx = {1'b0, ~fdcSel.driveIdx[0]};
    motor_nxt = swap ? {fdcSel.motorOn[0], fdcSel.motorOn[1]} : fdcSel.motorOn[1:0];
    if (fdcIde_r[POS_EXT_FOUR])
    begin
      // Encoded index for an outside 2-to-4 decoder; idle shows 00
      drvSel_nxt = fdcSel.driveActive ? swIdx : 2'h0;
    end
    else
    begin
      // Internal decode reaches drives 0 and 1 only
      drvSel_nxt = 2'h0;
      if (fdcSel.driveActive && !swIdx[1])
        drvSel_nxt[swIdx[0]] = 1'b1;
    end
    case (fdcIde_r[POS_DENSEL +: 2])
      DENSEL_FORCE_HIGH: densel_nxt = 1'b1;
      DENSEL_FORCE_LOW: densel_nxt = 1'b0;
      default: densel_nxt = denselIn;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      drvSel_r <= 2'h0;
      motor_r <= 2'h0;
      densel_r <= 1'b0;
    end
    else
    begin
      drvSel_r <= drvSel_nxt;
      motor_r <= motor_nxt;
      densel_r <= densel_nxt;
    end
  end

  assign driveSelect = drvSel_r;
  assign motorSelect = motor_r;
  assign densel = densel_r;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  a_par_reset: assert property (@(posedge clock) sys_rst |=> parSerial_r == 8'h00)
    else $error("parallel-serial setup not cleared by reset");
  a_drvtype_reset: assert property (@(posedge clock) sys_rst |=> driveTypes == 8'hff)
    else $error("drive type not FF after reset");
  a_write_gate: assert property (@(posedge clock) disable iff (sys_rst)
    !cfgMode |=> $stable(parSerial_r) && $stable(fdcIde_r) && $stable(drvType_r))
    else $error("register changed outside configuration mode");
  a_ro_bits_zero: assert property (@(posedge clock) disable iff (sys_rst)
    cfgMode && dataRd && index_r == 8'h05 |=> rdData[1:0] == 2'h0 && !rdData[7])
    else $error("read-only bits not zero");
  // A period is 12 or 13 clocks, the changeover period included
  a_div_period: assert property (@(posedge clock) disable iff (sys_rst)
    uartClkTick[0] |=> (!uartClkTick[0]) [*8] ##[4:5] uartClkTick[0])
    else $error("first UART divider period wrong");
  // Only the select seen at count 11 decides whether the period ends at 12
  a_div12_exact: assert property (@(posedge clock) disable iff (sys_rst)
    uartClkTick[1] ##11 div12Sel[1] |=> uartClkTick[1])
    else $error("second UART divide-by-12 period broken");
  a_nonburst_pulse: assert property (@(posedge clock) disable iff (sys_rst)
    nonBurst && floppyDmaRequest && !fdcByteDone && !$past(fdcByteDone) && $stable(nonBurst)
    |=> !floppyDmaRequest)
    else $error("non-burst request held over two cycles");
  a_burst_follow: assert property (@(posedge clock) disable iff (sys_rst)
    !nonBurst |=> floppyDmaRequest == $past(fdcDmaReqIn))
    else $error("burst request does not follow core");
  a_densel_force: assert property (@(posedge clock) disable iff (sys_rst) fdcIde_r[4:3] == 2'h3 |=> !densel)
    else $error("density select not forced low");
  a_swap_drive: assert property (@(posedge clock) disable iff (sys_rst)
    swap && !fdcIde_r[6] && fdcSel.driveActive && fdcSel.driveIdx == 2'h0 |=> driveSelect == 2'h2)
    else $error("drive 0 not swapped to 1");
  a_ecr_epp: assert property (@(posedge clock) disable iff (sys_rst)
    ecrModeWr && ecrMode == 3'h4 && parMode == 2'h3 && !(cfgMode && dataWr) |=> parOpMode == OP_EPP)
    else $error("ecr mode 100 did not select EPP");
  a_ecr_spp: assert property (@(posedge clock) disable iff (sys_rst)
    ecrModeWr && ecrMode == 3'h0 && parMode[1] && !(cfgMode && dataWr) |=> parOpMode == OP_SPP)
    else $error("ecr mode 000 did not select SPP");

  c_ecr_epp: cover property (@(posedge clock) disable iff (sys_rst) parOpMode == OP_ECP ##1 parOpMode == OP_EPP);
  c_nonburst: cover property (@(posedge clock) disable iff (sys_rst) nonBurst && floppyDmaRequest);
  c_ext_decode: cover property (@(posedge clock) disable iff (sys_rst) externalFourDriveDecode && driveSelect == 2'h3);

endmodule : esc_setup_regs

// *** dv/esc_setup_regs_test.sv ***
module esc_setup_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  import esc_pkg::*;

  logic clock, sys_rst, cfgMode, idxWr, dataWr, dataRd, ecrModeWr;
  logic fifoEnabled, fdcDmaReqIn, fdcIrqIn, fdcByteDone, denselIn, densel;
  logic [7:0] wrData, rdData, configIndexRegister, driveTypes, d;
  logic [2:0] ecrMode;
  logic [1:0] parMode, uartClkTick, driveSelect, motorSelect;
  logic parPinFloppyOptOne, parPinFloppyOptTwo, eppVersion17, uartOneDiv12Select, uartTwoDiv12Select;
  logic floppyDmaRequest, floppyInterruptRequest, externalFourDriveDecode, rdPend;
  esc_op_mode_t parOpMode;
  esc_fdc_sel_t fdcSel;
  int err_count, samples_checked, hd, hi;
  logic [7:0] expQ[$];
  logic [31:0] seed;
  // Drive-select table: setup value, drive index, expected selects and motors
  logic [7:0] dReg[4] = '{8'h00, 8'h20, 8'h60, 8'h40};
  logic [1:0] dIdx[4] = '{2'h0, 2'h0, 2'h0, 2'h3};
  logic [1:0] dDs[4] = '{2'h1, 2'h2, 2'h1, 2'h3};
  logic [1:0] dMs[4] = '{2'h1, 2'h2, 2'h2, 2'h1};

  esc_setup_regs i_dut (.clock, .sys_rst, .cfgMode, .idxWr, .dataWr, .dataRd, .wrData, .rdData,
    .configIndexRegister, .parMode, .parPinFloppyOptOne, .parPinFloppyOptTwo, .eppVersion17, .ecrModeWr,
    .ecrMode, .parOpMode, .uartOneDiv12Select, .uartTwoDiv12Select, .uartClkTick, .fifoEnabled,
    .fdcDmaReqIn, .fdcIrqIn, .fdcByteDone, .floppyDmaRequest, .floppyInterruptRequest, .denselIn,
    .densel, .fdcSel, .driveSelect, .motorSelect, .externalFourDriveDecode, .driveTypes);

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task results;
    $display("Errors %0d, checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task cyc;
    @(negedge clock);
  endtask : cyc

  // Index then data, back to back as the port allows
  task wr(input logic [7:0] idx, input logic [7:0] v);
    idxWr = 1'b1;
    wrData = idx;
    cyc;
    idxWr = 1'b0;
    dataWr = 1'b1;
    wrData = v;
    cyc;
    dataWr = 1'b0;
    cyc;
    cyc;
  endtask : wr

  task rd(input logic [7:0] idx, input logic [7:0] exp);
    idxWr = 1'b1;
    wrData = idx;
    cyc;
    idxWr = 1'b0;
    dataRd = 1'b1;
    expQ.push_back(exp);
    cyc;
    dataRd = 1'b0;
    cyc;
  endtask : rd

  task nxt(input int b, output int n);
    n = 0;
    do
    begin
      cyc;
      n++;
    end
    while (uartClkTick[b] !== 1'b1 && n < 40);
    if (n >= 40)
    begin
      err_count++;
      results;
    end
  endtask : nxt

  // First gap aligns and may close the changeover period, second and third are steady
  task per(input int b, input int ex);
    int n;
    nxt(b, n);
    nxt(b, n);
    nxt(b, n);
    chk(8'(n), 8'(ex));
  endtask : per

  task ecr(input logic [2:0] m);
    ecrMode = m;
    ecrModeWr = 1'b1;
    cyc;
    ecrModeWr = 1'b0;
    cyc;
    cyc;
  endtask : ecr

  task cnt;
    hd = 0;
    hi = 0;
    repeat (6)
    begin
      cyc;
      fdcByteDone = 1'b0;
      hd = hd + int'(floppyDmaRequest === 1'b1);
      hi = hi + int'(floppyInterruptRequest === 1'b1);
    end
  endtask : cnt

  ////////////////////////////////////////////////////////////////////////////
  // Read results appear one cycle after the taken strobe
  always @(posedge clock)
    rdPend <= dataRd & cfgMode & ~sys_rst;

  always @(negedge clock)
    if (rdPend === 1'b1)
    begin
      if (expQ.size() == 0)
        chk(rdData, 8'hxx);
      else
        chk(rdData, expQ.pop_front());
    end

  initial
  begin
    sys_rst = 1'b1;
    cfgMode = 1'b1;
    {idxWr, dataWr, dataRd, ecrModeWr, fifoEnabled, fdcDmaReqIn, fdcIrqIn, fdcByteDone, denselIn} = '0;
    wrData = 8'h00;
    ecrMode = 3'h0;
    fdcSel = '0;
    seed = 32'hdd9e;
    err_count = 0;
    samples_checked = 0;
    repeat (4) cyc;
    sys_rst = 1'b0;
    rd(8'h04, 8'h00);
    rd(8'h05, 8'h00);
    rd(8'h06, 8'hff);
    chk(driveTypes, 8'hff);
    rd(8'h07, 8'h00);
    // Strobes outside configuration mode must leave everything alone
    cfgMode = 1'b0;
    wr(8'h06, 8'h12);
    cfgMode = 1'b1;
    chk(configIndexRegister, 8'h07);
    rd(8'h06, 8'hff);
    repeat (6)
    begin
      seed = lfsr(seed);
      d = seed[7:0];
      wr(8'h04, d);
      wr(8'h05, d);
      wr(8'h06, ~d);
      rd(8'h04, d & 8'h7f);
      rd(8'h05, d & 8'h7c);
      rd(8'h06, ~d);
      chk(driveTypes, ~d);
      chk({6'h0, parMode}, {6'h0, d[1:0]});
      chk({6'h0, parOpMode}, {6'h0, d[1:0] == 2'h0 ? OP_SPP : d[1:0] == 2'h1 ? OP_EPP : OP_ECP});
      chk({3'h0, parPinFloppyOptOne, parPinFloppyOptTwo, eppVersion17, uartOneDiv12Select, uartTwoDiv12Select},
        {3'h0, d[3:2] == 2'h1, d[3:2] == 2'h2, d[6], d[4], d[5]});
      chk({7'h0, externalFourDriveDecode}, {7'h0, d[6]});
    end
    wr(8'h04, 8'h00);
    per(0, 13);
    per(1, 13);
    wr(8'h04, 8'h30);
    per(0, 12);
    per(1, 12);
    wr(8'h04, 8'h03);
    ecr(3'h4);
    chk({6'h0, parOpMode}, {6'h0, OP_EPP});
    ecr(3'h0);
    chk({6'h0, parOpMode}, {6'h0, OP_SPP});
    wr(8'h04, 8'h02);
    ecr(3'h4);
    chk({6'h0, parOpMode}, {6'h0, OP_ECP});
    for (int i = 0; i < 8; i++)
    begin
      denselIn = i[2];
      wr(8'h05, {3'h0, i[1:0], 3'h0});
      chk({7'h0, densel}, {7'h0, i[1:0] == 2'h2 ? 1'b1 : i[1:0] == 2'h3 ? 1'b0 : i[2]});
    end
    for (int i = 0; i < 4; i++)
    begin
      fdcSel = '{driveIdx: dIdx[i], driveActive: 1'b1, motorOn: 4'h1};
      wr(8'h05, dReg[i]);
      chk({4'h0, driveSelect, motorSelect}, {4'h0, dDs[i], dMs[i]});
    end
    // Non-burst with the FIFO on: one strobe per byte, not a held level
    wr(8'h05, 8'h04);
    fifoEnabled = 1'b1;
    fdcDmaReqIn = 1'b1;
    fdcIrqIn = 1'b1;
    cnt;
    chk(8'(hd * 16 + hi), 8'h11);
    fdcByteDone = 1'b1;
    cnt;
    chk(8'(hd * 16 + hi), 8'h11);
    {fdcDmaReqIn, fdcIrqIn} = 2'b00;
    wr(8'h05, 8'h00);
    {fdcDmaReqIn, fdcIrqIn} = 2'b11;
    cnt;
    chk(8'(hd * 16 + hi), 8'h66);
    cyc;
    results;
  end
endmodule : esc_setup_regs_test
